/* bench/lpdet_ctrl_model.sv */
// Controller model that counts the calls placed on each channel.
`timescale 1ns/1ps
module lpdet_ctrl_model (
   input  wire logic        sys_clk_i,
   input  wire logic        resetn_i,
   input  wire logic [1:0]  call_i,
   output logic      [15:0] calls0_o,
   output logic      [15:0] calls1_o
);
   logic [1:0] call_d_r;
   // A call is counted once, on its rising edge, as a real controller latches it.
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         call_d_r <= 2'h0;
         calls0_o <= 16'h0000;
         calls1_o <= 16'h0000;
      end else begin
         call_d_r <= call_i;
         if (call_i[0] && !call_d_r[0]) calls0_o <= calls0_o + 16'h0001;
         if (call_i[1] && !call_d_r[1]) calls1_o <= calls1_o + 16'h0001;
      end
   end
endmodule // lpdet_ctrl_model

/* bench/lpdet_top_assertions.sv */
// Concurrent checks on the ports of the loop detector option logic.
`timescale 1ns/1ps
`include "lpdet_defs.vh"
module lpdet_top_assertions (
   // Clock, reset, panel and green
   input wire logic        sys_clk_i,
   input wire logic        resetn_i,
   input wire logic [2:0]  opt_sel_i,
   input wire logic        up_i,
   input wire logic        down_i,
   input wire logic [1:0]  green_i,
   // Observed outputs
   input wire logic [1:0]  call_o,
   input wire logic [1:0]  pend_o,
   input wire logic        filt_byp_o,
   input wire logic        pair_and_o,
   input wire logic        dir_gate_o,
   input wire logic        chan_rst_o,
   input wire logic [5:0]  loop_cfg_o,
   input wire logic [1:0]  desens_o,
   input wire logic [19:0] desens_ppm_o,
   input wire logic [31:0] count_o,
   input wire logic [1:0]  disp_hi_o,
   input wire logic [1:0]  flash_o,
   input wire logic [1:0]  train_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   property p_byp_tog; (up_i || down_i) && opt_sel_i == `LPD_OPT_BYP
      |=> filt_byp_o != $past(filt_byp_o) && chan_rst_o; endproperty
   a_byp_tog: assert property (p_byp_tog) else $error("bypass press did not toggle");
   property p_rst_clr; chan_rst_o |=> call_o == 2'h0 && pend_o == 2'h0; endproperty
   a_rst_clr: assert property (p_rst_clr) else $error("channel reset left a call");
   property p_excl; !(pair_and_o && dir_gate_o); endproperty
   a_excl: assert property (p_excl) else $error("pairing and direction both on");
   property p_and; pair_and_o [*3] |-> call_o[0] == call_o[1]; endproperty
   a_and: assert property (p_and) else $error("paired calls differ");
   property p_pend; pend_o != 2'h0 |-> call_o == 2'h0 && pend_o != 2'h3; endproperty
   a_pend: assert property (p_pend) else $error("pending with a call");
   property p_ppm; desens_ppm_o[9:0] == (desens_o[0] ? `LPD_DESENS_PPM : `LPD_PPM_ZERO);
   endproperty
   a_ppm: assert property (p_ppm) else $error("desens level wrong");
   property p_nogreen; !green_i[0] [*3] |-> !desens_o[0]; endproperty
   a_nogreen: assert property (p_nogreen) else $error("desens without green");
   property p_step; $changed(count_o[15:0]) |-> count_o[15:0] == 16'h0000
      || count_o[15:0] == $past(count_o[15:0]) + 16'h0001; endproperty
   a_step: assert property (p_step) else $error("count moved by other than one");
   property p_lowdisp; (count_o[15:0] <= 16'h03E7) [*3] |-> !disp_hi_o[0]; endproperty
   a_lowdisp: assert property (p_lowdisp) else $error("high digits shown below 1000");
   property p_flash; !train_o[0] [*2] |-> !flash_o[0]; endproperty
   a_flash: assert property (p_flash) else $error("flash after training");
   property p_cfg; loop_cfg_o[2:0] >= 3'h1 && loop_cfg_o[2:0] <= 3'h4; endproperty
   a_cfg: assert property (p_cfg) else $error("loop count out of range");
endmodule // lpdet_top_assertions

bind lpdet_top lpdet_top_assertions u_chk (.sys_clk_i, .resetn_i, .opt_sel_i, .up_i, .down_i,
   .green_i, .call_o, .pend_o, .filt_byp_o, .pair_and_o, .dir_gate_o, .chan_rst_o, .loop_cfg_o,
   .desens_o, .desens_ppm_o, .count_o, .disp_hi_o, .flash_o, .train_o);

/* bench/lpdet_top_tb.sv */
// Self-checking testbench of the loop detector option logic.
`timescale 1ns/1ps
module lpdet_top_tb;
   logic sys_clk_i = 1'b0, resetn_i = 1'b0, chan_sel_i = 1'b0, up_i = 1'b0, down_i = 1'b0;
   logic [1:0] occ_i = 2'h0, span_i = 2'h0, green_i = 2'h0, sens_chg_i = 2'h0;
   logic [1:0] loop_fail_i = 2'h0, fail_clr_i = 2'h0;
   logic [2:0] opt_sel_i = 3'h0;
   wire [1:0] call_o, pend_o, desens_en_o, cnt_disp_o, desens_o, disp_hi_o, flash_o, train_o;
   wire [1:0] fail_ind_o;
   wire filt_byp_o, pair_and_o, dir_gate_o, clr_view_o, chan_rst_o;
   wire [5:0] loop_cfg_o;
   wire [19:0] desens_ppm_o;
   wire [31:0] count_o;
   wire [23:0] disp_dig_o;
   wire [15:0] fail_cnt_o, calls0, calls1;
   integer n_errors = 0, n_compared = 0, i, hi_n, lo_n;
   logic [15:0] c0, c1;
   always #5 sys_clk_i = ~sys_clk_i;
   lpdet_top #(.HALF_CYC(8), .TRAIN_VEH(2)) dut (.sys_clk_i, .resetn_i, .occ_i, .span_i,
      .green_i, .sens_chg_i, .loop_fail_i, .fail_clr_i, .opt_sel_i, .chan_sel_i, .up_i, .down_i,
      .call_o, .pend_o, .filt_byp_o, .pair_and_o, .dir_gate_o, .clr_view_o, .chan_rst_o,
      .loop_cfg_o, .desens_en_o, .cnt_disp_o, .desens_o, .desens_ppm_o, .count_o, .disp_dig_o,
      .disp_hi_o, .flash_o, .train_o, .fail_ind_o, .fail_cnt_o);
   lpdet_ctrl_model ctl (.sys_clk_i, .resetn_i, .call_i(call_o), .calls0_o(calls0),
      .calls1_o(calls1));
   task cyc(input integer n); begin repeat (n) @(posedge sys_clk_i); #1; end endtask
   task chk(input [31:0] got, input [31:0] exp, input [8*24-1:0] msg);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %0t %0s", $time, msg);
         end
      end
   endtask
   task press(input [2:0] opt, input ch, input dn);
      begin
         opt_sel_i = opt; chan_sel_i = ch; cyc(1);
         up_i = !dn; down_i = dn; cyc(1);
         up_i = 1'b0; down_i = 1'b0; cyc(3);
      end
   endtask
   task veh(input ch, input sp, input integer n);
      begin
         occ_i[ch] = 1'b1; span_i[ch] = sp; cyc(n);
         occ_i[ch] = 1'b0; span_i[ch] = 1'b0; cyc(n);
      end
   endtask
   task done(input [8*8-1:0] nm); $display("%0s finished, errors %0d", nm, n_errors); endtask
   task finish_test;
      begin
         $display("Compared %0d, errors %0d", n_compared, n_errors);
         if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial begin
      cyc(2); resetn_i = 1'b1; cyc(1);
      chk(train_o, 2'h3, "training at power-up");
      chk(loop_cfg_o, 6'h09, "loop count reset");
      chk(filt_byp_o, 1'b0, "bypass default");
      chk(count_o, 32'h0, "count after power-up");
      done("reset");
      loop_fail_i[0] = 1'b1; cyc(1); loop_fail_i[0] = 1'b0; cyc(3);
      press(3'h0, 1'b1, 1'b0);
      chk(filt_byp_o, 1'b1, "bypass on");
      chk({fail_ind_o[0], fail_cnt_o[7:0]}, 9'h101, "fail kept");
      press(3'h0, 1'b0, 1'b1);
      chk(filt_byp_o, 1'b0, "bypass off");
      done("bypass");
      press(3'h2, 1'b0, 1'b0); hi_n = 0;
      chk(cnt_disp_o[0], 1'b1, "count display on");
      for (i = 0; i < 20; i = i + 1) begin cyc(1); hi_n = hi_n + flash_o[0]; end
      chk(hi_n > 0, 1'b1, "no flash in training");
      for (i = 0; i < 3; i = i + 1) veh(1'b0, 1'b0, 12);
      chk(count_o[15:0], 16'h3, "three vehicles");
      chk(train_o[0], 1'b0, "training ended");
      chk({disp_hi_o[0], disp_dig_o[11:0]}, 13'h003, "low digits");
      done("count");
      press(3'h3, 1'b0, 1'b0);
      chk({clr_view_o, count_o[15:0]}, 17'h10000, "clear");
      veh(1'b0, 1'b0, 12); opt_sel_i = 3'h0; cyc(2); opt_sel_i = 3'h3; cyc(2);
      chk(clr_view_o, 1'b0, "view shows off");
      press(3'h3, 1'b0, 1'b0); veh(1'b0, 1'b0, 12); press(3'h3, 1'b0, 1'b0);
      chk({clr_view_o, count_o[15:0]}, 17'h00001, "on to off no clear");
      done("clear");
      veh(1'b1, 1'b0, 12); veh(1'b1, 1'b0, 12); press(3'h4, 1'b1, 1'b0);
      chk({loop_cfg_o[5:3], train_o[1]}, 4'h5, "retrain on cfg");
      veh(1'b1, 1'b0, 12); veh(1'b1, 1'b1, 12);
      chk(count_o[31:16], 16'h3, "span counting");
      press(3'h4, 1'b0, 1'b1);
      chk(loop_cfg_o[2:0], 3'h1, "down at one");
      for (i = 0; i < 3; i = i + 1) press(3'h4, 1'b1, 1'b0);
      chk(loop_cfg_o[5:3], 3'h4, "up at four");
      done("config");
      press(3'h5, 1'b1, 1'b0);
      chk({pair_and_o, dir_gate_o}, 2'h2, "pair on");
      press(3'h6, 1'b0, 1'b0);
      chk({pair_and_o, dir_gate_o}, 2'h1, "dir forces pair off");
      press(3'h5, 1'b0, 1'b1);
      chk({pair_and_o, dir_gate_o}, 2'h2, "pair forces dir off");
      c0 = calls0; c1 = calls1; occ_i[0] = 1'b1; cyc(12);
      chk({pend_o, call_o}, 4'h4, "pending alone");
      occ_i[1] = 1'b1; cyc(12);
      chk({pend_o, call_o}, 4'h3, "both occupied");
      occ_i = 2'h0; cyc(12);
      chk({call_o, calls0 - c0, calls1 - c1}, 34'h000010001, "calls served");
      chk(count_o, 32'h00030002, "counts while paired");
      done("pairing");
      press(3'h1, 1'b0, 1'b0);
      chk(desens_en_o, 2'h1, "desens setting");
      green_i = 2'h3; cyc(4);
      chk({desens_o, desens_ppm_o}, 22'h1001F4, "desens on green");
      green_i = 2'h0; cyc(4);
      chk({desens_o, desens_ppm_o}, 22'h0, "desens off");
      done("desens");
      press(3'h3, 1'b0, 1'b0); press(3'h0, 1'b0, 1'b0);
      for (i = 0; i < 1234; i = i + 1) veh(1'b0, 1'b0, 4);
      chk(count_o[15:0], 16'd1234, "bypass counting");
      hi_n = 0; lo_n = 0;
      for (i = 0; i < 40; i = i + 1) begin
         cyc(1);
         if (disp_hi_o[0] === 1'b1) begin
            hi_n = hi_n + 1; chk(disp_dig_o[11:0], 12'hF01, "high digits");
         end else begin
            lo_n = lo_n + 1; chk(disp_dig_o[11:0], 12'h234, "low digits");
         end
      end
      chk(hi_n > 0 && lo_n > 0, 1'b1, "no alternation");
      done("display");
      finish_test;
   end
   initial begin
      #400000;
      n_errors = n_errors + 1;
      $display("ERROR %0t watchdog expired", $time);
      finish_test;
   end
endmodule // lpdet_top_tb

/* src/lpdet_defs.vh */
// Shared constants of the loop detector option logic.
`ifndef LPDET_DEFS_VH
`define LPDET_DEFS_VH
// Option selector codes.
`define LPD_OPT_BYP      3'h0
`define LPD_OPT_DESENS   3'h1
`define LPD_OPT_CNTDISP  3'h2
`define LPD_OPT_CNTCLR   3'h3
`define LPD_OPT_LOOPCFG  3'h4
`define LPD_OPT_PAIR     3'h5
`define LPD_OPT_DIR      3'h6
// Loop-count setting limits and reset value.
`define LPD_LOOP_MIN     3'h1
`define LPD_LOOP_MAX     3'h4
`define LPD_LOOP_RST     3'h1
// Noise filter: consecutive agreeing samples before the filtered state moves.
`define LPD_FILT_LEN     4'h8
`define LPD_FILT_ZERO    4'h0
`define LPD_FILT_ONE     4'h1
// Desensitization ceiling: 0.05 percent, held as parts per million.
`define LPD_DESENS_PPM   10'h1F4
`define LPD_PPM_ZERO     10'h000
// Counter and display constants.
`define LPD_CNT_ZERO     16'h0000
`define LPD_CNT_ONE      16'h0001
`define LPD_CNT_LOWMAX   16'h03E7
`define LPD_DIG_BLANK    4'hF
`define LPD_TRN_ZERO     8'h00
`define LPD_TRN_ONE      8'h01
`define LPD_TRN_VEH      8'h10
`define LPD_FAIL_ZERO    8'h00
`define LPD_FAIL_ONE     8'h01
`define LPD_FAIL_MAX     8'hFF
// Display alternation and flash half period.
`define LPD_CLK_NS       10
`define LPD_HALF_NS      500000000
`define LPD_TICK_ZERO    27'h0000000
`define LPD_TICK_ONE     27'h0000001
`endif

/* src/lpdet_top.v */
// Two-channel loop detector option, counting and pairing logic.
`timescale 1ns/1ps
`include "lpdet_defs.vh"

// Limitations and intent of this block, for whoever picks it up next:
// The occupancy filter is a plain run-length counter on the raw occupancy level.
// A noisy loop that flips faster than the filter length never moves the filtered state.
// That is the stability the bypass trades away for a faster response.
// The channel reset on a bypass change clears only the filter, span tracking and calls.
// Counts, settings and the loop failure state are deliberately left alone, so that
// a technician who changes the filter does not lose the failure history.
// The count clear view is forced off on every entry, so each clear needs one fresh
// press after the view has been open for at least one cycle.
// Clearing a count on the same edge as a departure wins, and that vehicle is lost.
// The loss is accepted because the operator asked for zero at that instant.
// Training ends after a fixed number of counted vehicles; the real criterion of
// vehicle signature learning lives outside this block.
// Counting never looks at the call outputs, so pairing never hides a vehicle.
// The alternation and flash share one half-period tick to keep the display phases
// aligned; a count crossing 999 may show the high digits for less than a full half period.
// Direction gating is only held here as a flag; its call logic lives elsewhere.
// The only job of the flag in this block is to stay exclusive with AND pairing.
// The desensitization level is exported as a fixed ceiling; the analogue side applies it.
// All outputs are registered, so per-channel settings appear two cycles after a press.
// Shared option bits appear one cycle after a press, since they are output registers.
// Up and down pressed together count as up for the loop-count setting.
// Loop-count presses beyond the ends are ignored and do not restart training.
// A sensitivity change restarts training on that channel only.
// The failure counter saturates rather than wrapping, so a flood of faults stays visible.
// Failure indications are set by the fault input and win over a simultaneous clear.

module lpdet_top #(
   parameter HALF_CYC  = `LPD_HALF_NS / `LPD_CLK_NS,
   parameter TRAIN_VEH = `LPD_TRN_VEH
) (
   // Clock and reset
   input  wire        sys_clk_i,
   input  wire        resetn_i,
   // Loop sensing, one bit per channel
   input  wire [1:0]  occ_i,
   input  wire [1:0]  span_i,
   input  wire [1:0]  green_i,
   input  wire [1:0]  sens_chg_i,
   input  wire [1:0]  loop_fail_i,
   input  wire [1:0]  fail_clr_i,
   // Front panel
   input  wire [2:0]  opt_sel_i,
   input  wire        chan_sel_i,
   input  wire        up_i,
   input  wire        down_i,
   // Calls to the controller
   output reg  [1:0]  call_o,
   output reg  [1:0]  pend_o,
   // Option state
   output reg         filt_byp_o,
   output reg         pair_and_o,
   output reg         dir_gate_o,
   output reg         clr_view_o,
   output reg         chan_rst_o,
   output reg  [5:0]  loop_cfg_o,
   output reg  [1:0]  desens_en_o,
   output reg  [1:0]  cnt_disp_o,
   // Compensation and display
   output reg  [1:0]  desens_o,
   output reg  [19:0] desens_ppm_o,
   output reg  [31:0] count_o,
   output reg  [23:0] disp_dig_o,
   output reg  [1:0]  disp_hi_o,
   output reg  [1:0]  flash_o,
   output reg  [1:0]  train_o,
   // Loop failure
   output reg  [1:0]  fail_ind_o,
   output reg  [15:0] fail_cnt_o
);

   reg  [26:0] tick_cnt_r;
   reg         phase_r;
   reg  [2:0]  opt_last_r;
   wire        press;
   wire        tick;
   wire        shared_sel;
   wire [1:0]  filt;

   assign press = up_i | down_i;
   assign tick = (tick_cnt_r == HALF_CYC[26:0] - `LPD_TICK_ONE);
   assign shared_sel = press & (opt_sel_i == `LPD_OPT_BYP);

   // Five-digit BCD of a 16-bit count, nibble 4 is ten-thousands.
   function [19:0] to_bcd;
      input [15:0] bin;
      reg   [35:0] sh;
      integer      k;
      begin
         sh = {20'h00000, bin};
         for (k = 0; k < 16; k = k + 1) begin
            if (sh[19:16] > 4'h4) sh[19:16] = sh[19:16] + 4'h3;
            if (sh[23:20] > 4'h4) sh[23:20] = sh[23:20] + 4'h3;
            if (sh[27:24] > 4'h4) sh[27:24] = sh[27:24] + 4'h3;
            if (sh[31:28] > 4'h4) sh[31:28] = sh[31:28] + 4'h3;
            if (sh[35:32] > 4'h4) sh[35:32] = sh[35:32] + 4'h3;
            sh = {sh[34:0], 1'b0};
         end
         to_bcd = sh[35:16];
      end
   endfunction

   // One half-period tick drives both alternation and flashing.
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_cnt_r <= `LPD_TICK_ZERO;
         phase_r    <= 1'b0;
      end else if (tick) begin
         tick_cnt_r <= `LPD_TICK_ZERO;
         phase_r    <= ~phase_r;
      end else begin
         tick_cnt_r <= tick_cnt_r + `LPD_TICK_ONE;
      end
   end

   // Detector-wide options and the shared pair bits.
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         filt_byp_o <= 1'b0;
         pair_and_o <= 1'b0;
         dir_gate_o <= 1'b0;
         chan_rst_o <= 1'b0;
         clr_view_o <= 1'b0;
         opt_last_r <= `LPD_OPT_BYP;
      end else begin
         opt_last_r <= opt_sel_i;
         if (shared_sel) filt_byp_o <= ~filt_byp_o;
         chan_rst_o <= shared_sel;
         if (press && opt_sel_i == `LPD_OPT_PAIR) begin
            pair_and_o <= ~pair_and_o;
            if (!pair_and_o) dir_gate_o <= 1'b0;
         end else if (press && opt_sel_i == `LPD_OPT_DIR) begin
            dir_gate_o <= ~dir_gate_o;
            if (!dir_gate_o) pair_and_o <= 1'b0;
         end
         if (opt_sel_i != `LPD_OPT_CNTCLR || opt_last_r != `LPD_OPT_CNTCLR) begin
            clr_view_o <= 1'b0;
         end else if (press) begin
            clr_view_o <= ~clr_view_o;
         end
      end
   end

   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_ch
         reg  [3:0]  filt_cnt_r;
         reg         filt_r;
         reg         span_seen_r;
         reg  [15:0] count_r;
         reg  [7:0]  trn_cnt_r;
         reg         train_r;
         reg  [2:0]  loop_cfg_r;
         reg         desens_en_r;
         reg         cnt_disp_r;
         reg         fail_ind_r;
         reg  [7:0]  fail_cnt_r;
         wire        sel;
         wire        depart;
         wire        counted;
         wire        clr_hit;
         wire        cfg_chg;
         wire [19:0] bcd;

         assign sel = (chan_sel_i == i);
         assign filt[i] = filt_r;
         assign depart = filt_r & ~occ_i[i] & (filt_byp_o | filt_cnt_r == `LPD_FILT_LEN - `LPD_FILT_ONE);
         assign counted = depart & ((loop_cfg_r == `LPD_LOOP_MIN) | span_seen_r | span_i[i]);
         assign clr_hit = sel & press & ~clr_view_o & (opt_sel_i == `LPD_OPT_CNTCLR)
                          & (opt_last_r == `LPD_OPT_CNTCLR);
         assign cfg_chg = sel & press & (opt_sel_i == `LPD_OPT_LOOPCFG)
                          & ((up_i & loop_cfg_r != `LPD_LOOP_MAX)
                          | (down_i & ~up_i & loop_cfg_r != `LPD_LOOP_MIN));
         assign bcd = to_bcd(count_r);

         // Occupancy filter: a move needs FILT_LEN agreeing samples.
         always @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               filt_cnt_r  <= `LPD_FILT_ZERO;
               filt_r      <= 1'b0;
               span_seen_r <= 1'b0;
            end else if (chan_rst_o) begin
               filt_cnt_r  <= `LPD_FILT_ZERO;
               filt_r      <= 1'b0;
               span_seen_r <= 1'b0;
            end else begin
               if (occ_i[i] == filt_r) begin
                  filt_cnt_r <= `LPD_FILT_ZERO;
               end else if (filt_byp_o || filt_cnt_r == `LPD_FILT_LEN - `LPD_FILT_ONE) begin
                  filt_cnt_r <= `LPD_FILT_ZERO;
                  filt_r     <= occ_i[i];
               end else begin
                  filt_cnt_r <= filt_cnt_r + `LPD_FILT_ONE;
               end
               if (depart) span_seen_r <= 1'b0;
               else if (filt_r && span_i[i]) span_seen_r <= 1'b1;
            end
         end

         // Counter, training and per-channel settings.
         always @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               count_r     <= `LPD_CNT_ZERO;
               trn_cnt_r   <= `LPD_TRN_ZERO;
               train_r     <= 1'b1;
               loop_cfg_r  <= `LPD_LOOP_RST;
               desens_en_r <= 1'b0;
               cnt_disp_r  <= 1'b0;
            end else begin
               if (clr_hit) count_r <= `LPD_CNT_ZERO;
               else if (counted) count_r <= count_r + `LPD_CNT_ONE;
               if (cfg_chg || sens_chg_i[i]) begin
                  train_r   <= 1'b1;
                  trn_cnt_r <= `LPD_TRN_ZERO;
               end else if (train_r && counted) begin
                  trn_cnt_r <= trn_cnt_r + `LPD_TRN_ONE;
                  if (trn_cnt_r + `LPD_TRN_ONE >= TRAIN_VEH[7:0]) train_r <= 1'b0;
               end
               if (cfg_chg && up_i) loop_cfg_r <= loop_cfg_r + 3'h1;
               else if (cfg_chg) loop_cfg_r <= loop_cfg_r - 3'h1;
               if (sel && press && opt_sel_i == `LPD_OPT_DESENS) desens_en_r <= ~desens_en_r;
               if (sel && press && opt_sel_i == `LPD_OPT_CNTDISP) cnt_disp_r <= ~cnt_disp_r;
            end
         end

         // Loop failure is kept apart from the bypass channel reset.
         always @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               fail_ind_r <= 1'b0;
               fail_cnt_r <= `LPD_FAIL_ZERO;
            end else begin
               if (loop_fail_i[i]) fail_ind_r <= 1'b1;
               else if (fail_clr_i[i]) fail_ind_r <= 1'b0;
               if (loop_fail_i[i] && !fail_ind_r && fail_cnt_r != `LPD_FAIL_MAX) begin
                  fail_cnt_r <= fail_cnt_r + `LPD_FAIL_ONE;
               end
            end
         end

         // Registered per-channel outputs.
         always @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               desens_o[i]              <= 1'b0;
               desens_ppm_o[10*i+9:10*i] <= `LPD_PPM_ZERO;
               count_o[16*i+15:16*i]    <= `LPD_CNT_ZERO;
               disp_dig_o[12*i+11:12*i] <= 12'h000;
               disp_hi_o[i]             <= 1'b0;
               flash_o[i]               <= 1'b0;
               train_o[i]               <= 1'b1;
               loop_cfg_o[3*i+2:3*i]    <= `LPD_LOOP_RST;
               desens_en_o[i]           <= 1'b0;
               cnt_disp_o[i]            <= 1'b0;
               fail_ind_o[i]            <= 1'b0;
               fail_cnt_o[8*i+7:8*i]    <= `LPD_FAIL_ZERO;
            end else begin
               desens_o[i] <= desens_en_r & green_i[i];
               desens_ppm_o[10*i+9:10*i] <= (desens_en_r & green_i[i]) ? `LPD_DESENS_PPM
                                                                      : `LPD_PPM_ZERO;
               count_o[16*i+15:16*i] <= count_r;
               if (count_r > `LPD_CNT_LOWMAX && phase_r) begin
                  disp_dig_o[12*i+11:12*i] <= {`LPD_DIG_BLANK, bcd[19:12]};
                  disp_hi_o[i] <= 1'b1;
               end else begin
                  disp_dig_o[12*i+11:12*i] <= bcd[11:0];
                  disp_hi_o[i] <= 1'b0;
               end
               flash_o[i] <= cnt_disp_r & train_r & phase_r;
               train_o[i] <= train_r;
               loop_cfg_o[3*i+2:3*i] <= loop_cfg_r;
               desens_en_o[i] <= desens_en_r;
               cnt_disp_o[i] <= cnt_disp_r;
               fail_ind_o[i] <= fail_ind_r;
               fail_cnt_o[8*i+7:8*i] <= fail_cnt_r;
            end
         end
      end
   endgenerate

   // Call outputs; pairing gates the filtered occupancy.
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         call_o <= 2'h0;
         pend_o <= 2'h0;
      end else if (chan_rst_o) begin
         call_o <= 2'h0;
         pend_o <= 2'h0;
      end else if (pair_and_o) begin
         call_o <= {2{filt[0] & filt[1]}};
         pend_o <= filt & ~{filt[0], filt[1]};
      end else begin
         call_o <= filt;
         pend_o <= 2'h0;
      end
   end

endmodule // lpdet_top
